// ==== hw/io_port_map.svh ====
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH

`define N_PORTS        7
`define PORT_W         8
`define PINS_W         56
`define SYNC_W         58
`define LAST_PORT      3'h6
`define PORT_A         3'h0
`define PORT_D         3'h3
`define PORT_E         3'h4
`define PORT_F         3'h5
`define PORT_G         3'h6
`define REG_DIN        3'h0
`define REG_DOUT       3'h1
`define REG_DIR        3'h2
`define REG_CTRL       3'h3
`define REG_DRV        3'h4
`define REG_CELL       3'h5
`define PORT_D_MASK    8'h0F
`define PORT_FULL_MASK 8'hFF
`define RST_BYTE       8'h00
`define WB_ZERO        32'h0000_0000
`define LOGIC_OUT_SET  7'h07
`define LOGIC_IN_SET   7'h2F
`define ADDR_OUT_SET   7'h70
`define LOW_NIBBLE     8'h0F
`define HIGH_NIBBLE    8'hF0

`endif

// ==== hw/io_port_pkg.sv ====
package io_port_pkg;

	typedef enum logic [1:0]
	{
		HOST_MUX8   = 2'b00,
		HOST_BURST  = 2'b01,
		HOST_PAGE   = 2'b10,
		HOST_NONMUX = 2'b11
	} host_bus_e;

	typedef enum logic [1:0]
	{
		SRC_HOST  = 2'b00,
		SRC_ADDR  = 2'b01,
		SRC_LOGIC = 2'b10,
		SRC_NONE  = 2'b11
	} pin_src_e;

	typedef logic [7:0] port_byte_t;

endpackage

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`include "io_port_map.svh"

module pin_sync
(
	input  wire logic [`SYNC_W-1:0] async_i,
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	output logic      [`SYNC_W-1:0] sync_o
);

	logic [`SYNC_W-1:0] meta_q;
	logic [`SYNC_W-1:0] stable_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q   <= '0;
			stable_q <= '0;
		end
		else
		begin
			meta_q   <= async_i;
			stable_q <= meta_q;
		end
	end

	assign sync_o = stable_q;

endmodule

// ==== hw/port_pin_mux.sv ====
`timescale 1ns/1ps
`include "io_port_map.svh"

module port_pin_mux
#(
	parameter int PORT = 0
)
(
	input  wire io_port_pkg::port_byte_t dout_i,
	input  wire io_port_pkg::port_byte_t dir_i,
	input  wire io_port_pkg::port_byte_t ctrl_i,
	input  wire io_port_pkg::port_byte_t logic_out_i,
	input  wire io_port_pkg::port_byte_t logic_oe_i,
	input  wire io_port_pkg::port_byte_t cfg_logic_out_i,
	input  wire io_port_pkg::port_byte_t cfg_logic_in_i,
	input  wire io_port_pkg::port_byte_t cfg_addr_in_i,
	input  wire io_port_pkg::port_byte_t cfg_reset_i,
	input  wire logic [15:0]             addr_i,
	input  wire io_port_pkg::host_bus_e  host_type_i,
	input  wire logic                    cfg_data_port_i,
	input  wire logic                    cfg_test_port_i,
	output io_port_pkg::port_byte_t      out_o,
	output io_port_pkg::port_byte_t      oe_o
);

	localparam logic [6:0] LOGIC_OUT_OK = `LOGIC_OUT_SET;
	localparam logic [6:0] ADDR_OUT_OK  = `ADDR_OUT_SET;
	localparam logic [7:0] PIN_MASK     = (PORT == 3) ? `PORT_D_MASK : `PORT_FULL_MASK;

	io_port_pkg::port_byte_t addr_byte;
	io_port_pkg::port_byte_t addr_ok;
	logic                    port_off;

	// Latched address lanes per host bus type
	always_comb
	begin
		addr_byte = addr_i[7:0];
		addr_ok   = '0;
		unique case (host_type_i)
			io_port_pkg::HOST_MUX8:
				addr_ok = `PORT_FULL_MASK;
			io_port_pkg::HOST_BURST:
			begin
				addr_byte = (PORT == 6) ? {4'h0, addr_i[11:8]} : addr_i[7:0];
				addr_ok   = (PORT == 6) ? `LOW_NIBBLE : `HIGH_NIBBLE;
			end
			io_port_pkg::HOST_PAGE:
			begin
				addr_byte = addr_i[15:8];
				addr_ok   = (PORT == 6) ? `PORT_FULL_MASK : 8'h00;
			end
			io_port_pkg::HOST_NONMUX:
				addr_ok = (PORT == 6) ? `PORT_FULL_MASK : 8'h00;
		endcase
	end

	// Data port on F and test port on E take the whole port away
	assign port_off = (PORT == 5 && cfg_data_port_i) || (PORT == 4 && cfg_test_port_i);

	genvar b;
	generate
		for (b = 0; b < 8; b++)
		begin : g_bit
			io_port_pkg::pin_src_e src;
			always_comb
			begin
				if (port_off || cfg_logic_in_i[b] || cfg_addr_in_i[b] || cfg_reset_i[b])
					src = io_port_pkg::SRC_NONE;
				else if (LOGIC_OUT_OK[PORT] && cfg_logic_out_i[b])
					src = io_port_pkg::SRC_LOGIC;
				else if (ADDR_OUT_OK[PORT] && ctrl_i[b])
					src = io_port_pkg::SRC_ADDR;
				else
					src = io_port_pkg::SRC_HOST;
				unique case (src)
					io_port_pkg::SRC_HOST:
					begin
						out_o[b] = dout_i[b];
						oe_o[b]  = dir_i[b] & PIN_MASK[b];
					end
					io_port_pkg::SRC_ADDR:
					begin
						out_o[b] = addr_byte[b];
						oe_o[b]  = addr_ok[b] & (dir_i[b] | logic_oe_i[b]);
					end
					io_port_pkg::SRC_LOGIC:
					begin
						out_o[b] = logic_out_i[b];
						oe_o[b]  = logic_oe_i[b];
					end
					io_port_pkg::SRC_NONE:
					begin
						out_o[b] = 1'b0;
						oe_o[b]  = 1'b0;
					end
				endcase
			end
		end
	endgenerate

endmodule

// ==== hw/io_port_mode_config.sv ====
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "io_port_map.svh"

module io_port_mode_config
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic [`PINS_W-1:0]      pin_i,
	output logic      [`PINS_W-1:0]      pin_o,
	output logic      [`PINS_W-1:0]      pin_oe_o,
	output logic      [`PINS_W-1:0]      pin_to_logic_o,
	output logic      [`PINS_W-1:0]      drive_sel_o,
	input  wire logic [`PINS_W-1:0]      logic_out_i,
	input  wire logic [`PINS_W-1:0]      logic_oe_i,
	input  wire logic [15:0]             addr_latch_i,
	input  wire io_port_pkg::host_bus_e  host_type_i,
	input  wire logic [`PINS_W-1:0]      cfg_logic_out_i,
	input  wire logic [`PINS_W-1:0]      cfg_logic_in_i,
	input  wire logic [`PINS_W-1:0]      cfg_addr_in_i,
	input  wire logic [`PINS_W-1:0]      cfg_reset_i,
	input  wire logic                    cfg_data_port_i,
	input  wire logic                    cfg_test_port_i,
	input  wire logic                    cfg_strobe_en_i,
	input  wire logic                    host_e_i,
	input  wire logic                    host_rw_i,
	output logic                         ext_rd_o,
	output logic                         ext_wr_o
);

	// ------------------------------------------------------------
	// Pin and strobe synchronisers
	// ------------------------------------------------------------

	logic [`SYNC_W-1:0] sync_w;
	logic [`PINS_W-1:0] pin_s;
	logic               e_s;
	logic               rw_s;

	pin_sync u_sync
	(
		.async_i (
		{
			host_rw_i,
			host_e_i,
			pin_i
		}),
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.sync_o  (sync_w)
	);

	assign pin_s = sync_w[`PINS_W-1:0];
	assign e_s   = sync_w[`PINS_W];
	assign rw_s  = sync_w[`PINS_W+1];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	logic [`N_PORTS-1:0][`PORT_W-1:0] dout_q;
	logic [`N_PORTS-1:0][`PORT_W-1:0] dout_d;
	logic [`N_PORTS-1:0][`PORT_W-1:0] dir_q;
	logic [`N_PORTS-1:0][`PORT_W-1:0] dir_d;
	logic [`N_PORTS-1:0][`PORT_W-1:0] drv_q;
	logic [`N_PORTS-1:0][`PORT_W-1:0] drv_d;
	logic [2:0][`PORT_W-1:0]          ctrl_q;
	logic [2:0][`PORT_W-1:0]          ctrl_d;
	logic [`N_PORTS-1:0][`PORT_W-1:0] pin_ports;
	logic [`N_PORTS-1:0][`PORT_W-1:0] cell_ports;
	logic                             ack_q;
	logic                             ack_d;
	logic [31:0]                      rdat_q;
	logic [31:0]                      rdat_d;
	logic                             req;
	logic [2:0]                       reg_sel;
	logic [2:0]                       port_sel;
	logic [2:0]                       ctrl_off;
	logic [1:0]                       ctrl_idx;
	logic                             port_ok;
	logic                             ctrl_ok;
	logic [7:0]                       mask;
	logic [7:0]                       wbyte;
	logic [7:0]                       rb_byte;

	assign pin_ports  = pin_s;
	assign cell_ports = logic_out_i;
	assign req        = wb_cyc_i & wb_stb_i;
	assign reg_sel    = wb_adr_i[7:5];
	assign port_sel   = wb_adr_i[4:2];
	assign port_ok    = port_sel <= `LAST_PORT;
	assign ctrl_ok    = port_ok && (port_sel >= `PORT_E);
	assign ctrl_off   = port_sel - `PORT_E;
	assign ctrl_idx   = ctrl_off[1:0];
	// Port D has no upper nibble, so those bits never store and read zero
	assign mask       = (port_sel == `PORT_D) ? `PORT_D_MASK : `PORT_FULL_MASK;
	assign wbyte      = wb_dat_i[7:0] & mask;

	// Readback buffer: one source per access
	always_comb
	begin
		rb_byte = `RST_BYTE;
		if (port_ok)
		begin
			case (reg_sel)
				`REG_DIN:  rb_byte = pin_ports[port_sel] & mask;
				`REG_DOUT: rb_byte = dout_q[port_sel];
				`REG_DIR:  rb_byte = dir_q[port_sel];
				`REG_CTRL: rb_byte = ctrl_ok ? ctrl_q[ctrl_idx] : `RST_BYTE;
				`REG_DRV:  rb_byte = drv_q[port_sel];
				`REG_CELL: rb_byte = cell_ports[port_sel] & mask;
				default:   rb_byte = `RST_BYTE;
			endcase
		end
	end

	// Single-wait-state answer: ack one cycle after the request is seen
	always_comb
	begin
		dout_d = dout_q;
		dir_d  = dir_q;
		drv_d  = drv_q;
		ctrl_d = ctrl_q;
		ack_d  = 1'b0;
		rdat_d = `WB_ZERO;
		if (req && !ack_q)
		begin
			ack_d = 1'b1;
			if (!wb_we_i)
				rdat_d = {24'h00_0000, rb_byte};
			else if (wb_sel_i[0] && port_ok)
			begin
				case (reg_sel)
					`REG_DOUT: dout_d[port_sel] = wbyte;
					`REG_DIR:  dir_d[port_sel]  = wbyte;
					`REG_DRV:  drv_d[port_sel]  = wbyte;
					`REG_CTRL:
					begin
						if (ctrl_ok)
							ctrl_d[ctrl_idx] = wbyte;
					end
					default:   dout_d = dout_q;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dout_q <= '0;
			dir_q  <= '0;
			drv_q  <= '0;
			ctrl_q <= '0;
			ack_q  <= 1'b0;
			rdat_q <= `WB_ZERO;
		end
		else
		begin
			dout_q <= dout_d;
			dir_q  <= dir_d;
			drv_q  <= drv_d;
			ctrl_q <= ctrl_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = rdat_q;
	assign drive_sel_o = drv_q;

	// ------------------------------------------------------------
	// Output multiplexers
	// ------------------------------------------------------------

	logic [`PINS_W-1:0] mux_out_w;
	logic [`PINS_W-1:0] mux_oe_w;

	genvar p;
	generate
		for (p = 0; p < `N_PORTS; p++)
		begin : g_port
			io_port_pkg::port_byte_t ctrl_w;
			if (p >= 4)
			begin : g_ctrl
				assign ctrl_w = ctrl_q[p-4];
			end
			else
			begin : g_noctrl
				assign ctrl_w = `RST_BYTE;
			end
			port_pin_mux #(.PORT(p)) u_mux
			(
				.dout_i          (dout_q[p]),
				.dir_i           (dir_q[p]),
				.ctrl_i          (ctrl_w),
				.logic_out_i     (logic_out_i[p*8 +: 8]),
				.logic_oe_i      (logic_oe_i[p*8 +: 8]),
				.cfg_logic_out_i (cfg_logic_out_i[p*8 +: 8]),
				.cfg_logic_in_i  (cfg_logic_in_i[p*8 +: 8]),
				.cfg_addr_in_i   (cfg_addr_in_i[p*8 +: 8]),
				.cfg_reset_i     (cfg_reset_i[p*8 +: 8]),
				.addr_i          (addr_latch_i),
				.host_type_i     (host_type_i),
				.cfg_data_port_i (cfg_data_port_i),
				.cfg_test_port_i (cfg_test_port_i),
				.out_o           (mux_out_w[p*8 +: 8]),
				.oe_o            (mux_oe_w[p*8 +: 8])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Pin and strobe outputs
	// ------------------------------------------------------------

	logic [`PINS_W-1:0] pin_q;
	logic [`PINS_W-1:0] pin_d;
	logic [`PINS_W-1:0] oe_q;
	logic [`PINS_W-1:0] oe_d;
	logic [`PINS_W-1:0] to_logic_q;
	logic [`PINS_W-1:0] to_logic_d;
	logic               rd_q;
	logic               rd_d;
	logic               wr_q;
	logic               wr_d;

	always_comb
	begin
		pin_d      = mux_out_w;
		oe_d       = mux_oe_w;
		to_logic_d = pin_s;
		rd_d       = cfg_strobe_en_i & e_s & rw_s;
		wr_d       = cfg_strobe_en_i & e_s & ~rw_s;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_q      <= '0;
			oe_q       <= '0;
			to_logic_q <= '0;
			rd_q       <= 1'b0;
			wr_q       <= 1'b0;
		end
		else
		begin
			pin_q      <= pin_d;
			oe_q       <= oe_d;
			to_logic_q <= to_logic_d;
			rd_q       <= rd_d;
			wr_q       <= wr_d;
		end
	end

	assign pin_o          = pin_q;
	assign pin_oe_o       = oe_q;
	assign pin_to_logic_o = to_logic_q;
	assign ext_rd_o       = rd_q;
	assign ext_wr_o       = wr_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic a_port_a_free;
	assign a_port_a_free = (cfg_logic_out_i[7:0] | cfg_logic_in_i[7:0]
		| cfg_addr_in_i[7:0] | cfg_reset_i[7:0]) == 8'h00;

	sequence s_dir_a_write;
		req && !wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == {`REG_DIR, `PORT_A, 2'b00} && a_port_a_free;
	endsequence

	sequence s_dir_a_read;
		req && !wb_ack_o && !wb_we_i && wb_adr_i == {`REG_DIR, `PORT_A, 2'b00};
	endsequence

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");

	a_reset_clear: assert property ($fell(rst_i) |-> dir_q == '0 && ctrl_q == '0 && drv_q == '0)
		else $error("configuration registers not zero after reset");

	a_dir_drives: assert property (s_dir_a_write ##1 a_port_a_free
		|=> pin_oe_o[7:0] == $past(wb_dat_i[7:0], 2))
		else $error("port A enables do not follow direction write");

	a_dir_readback: assert property (s_dir_a_read |=> wb_ack_o && wb_dat_o[7:0] == $past(dir_q[0]))
		else $error("direction readback mismatch");

	a_port_f_quiet: assert property (cfg_data_port_i |=> pin_oe_o[47:40] == 8'h00)
		else $error("port F driven while data port");

	a_logic_in_quiet: assert property (##1 (pin_oe_o & $past(cfg_logic_in_i)) == '0)
		else $error("logic input pin driven");

	a_port_d_narrow: assert property (pin_oe_o[31:28] == 4'h0 && dir_q[3][7:4] == 4'h0)
		else $error("absent port D pins active");

	a_addr_out_g: assert property (ctrl_q[2][0] && dir_q[6][0] && cfg_reset_i[48] == 1'b0
		&& !cfg_logic_in_i[48] && !cfg_addr_in_i[48] && host_type_i == io_port_pkg::HOST_MUX8
		|=> pin_oe_o[48] && pin_o[48] == $past(addr_latch_i[0]))
		else $error("port G address bit not driven");

	a_rd_strobe: assert property (cfg_strobe_en_i && e_s && rw_s |=> ext_rd_o && !ext_wr_o)
		else $error("read strobe not produced");

	a_abc_no_addr: assert property (##1 (pin_oe_o[23:0] & ~$past(dir_q[2:0])
		& ~$past(logic_oe_i[23:0])) == 24'h00_0000)
		else $error("ports A-C driven without enable");

endmodule

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host controller on the register bus
// ----------------------------------------
module host_model
(
	input  wire logic        clk_i,
	input  wire logic [31:0] rdat_i,
	input  wire logic        ack_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end

	// Request stays put until ack is sampled; read data is taken at that edge
	task automatic xfer(input logic w, input int k, input int p, input logic [7:0] v,
		output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		sel_o <= 4'h1;
		adr_o <= {k[2:0], p[2:0], 2'b00};
		dat_o <= {24'h00_0000, v};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 50);
		r = rdat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= 1'b0;
		if (n >= 50)
			io_port_mode_config_bench.timeout_hit();
	endtask
endmodule

// ==== bench/io_port_mode_config_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) check(64'(a), 64'(b))
module io_port_mode_config_bench;
	logic                   clk_i     = 1'b0;
	logic                   rst_i     = 1'b1;
	logic                   cyc, stb, we, ack;
	logic [7:0]             adr;
	logic [3:0]             sel;
	logic [31:0]            wdat, rdat, r;
	logic [55:0]            pin_i     = 56'h00_0000_0000_0000;
	logic [55:0]            lo_out    = 56'h00_0000_0000_0000;
	logic [55:0]            lo_oe     = 56'h00_0000_0000_0000;
	logic [55:0]            c_lout    = 56'h00_0000_0000_0000;
	logic [55:0]            c_lin     = 56'h00_0000_0000_0000;
	logic [55:0]            c_ain     = 56'h00_0000_0000_0000;
	logic [55:0]            c_rst     = 56'h00_0000_0000_0000;
	logic [55:0]            pin_o, pin_oe_o, to_logic, drv;
	logic [15:0]            addr      = 16'h0000;
	io_port_pkg::host_bus_e ht        = io_port_pkg::HOST_MUX8;
	logic                   strobe_en = 1'b0;
	logic                   he        = 1'b0;
	logic                   hrw       = 1'b0;
	logic                   dport     = 1'b0;
	logic                   tport     = 1'b0;
	logic                   ext_rd, ext_wr;
	logic [23:0]            eo, ev;
	logic [7:0]             m [1:4][0:6];
	int                     n_errors  = 0;
	int                     compares  = 0;
	int                     seed      = 78;

	initial forever #2 clk_i = ~clk_i;

	io_port_mode_config io_port_mode_config_inst
	(
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_to_logic_o(to_logic),
		.drive_sel_o(drv), .logic_out_i(lo_out), .logic_oe_i(lo_oe), .addr_latch_i(addr),
		.host_type_i(ht), .cfg_logic_out_i(c_lout), .cfg_logic_in_i(c_lin),
		.cfg_addr_in_i(c_ain), .cfg_reset_i(c_rst),
		.cfg_data_port_i(dport), .cfg_test_port_i(tport), .cfg_strobe_en_i(strobe_en),
		.host_e_i(he), .host_rw_i(hrw), .ext_rd_o(ext_rd), .ext_wr_o(ext_wr)
	);

	host_model host_model_inst
	(
		.clk_i(clk_i), .rdat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
	);

	// ----------------------------------------
	// Checking and reference model
	// ----------------------------------------
	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic timeout_hit();
		n_errors++;
		report_and_stop();
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Port D has only four pins, so only its low nibble is stored
	function automatic logic [7:0] mask(int p);
		return (p == 3) ? 8'h0F : 8'hFF;
	endfunction

	task automatic wr(int k, int p, logic [7:0] v);
		host_model_inst.xfer(1'b1, k, p, v, r);
		if (p < 7 && k >= 1 && k <= 4 && (k != 3 || p >= 4))
			m[k][p] = v & mask(p);
	endtask

	task automatic rd_reg(int k, int p);
		host_model_inst.xfer(1'b0, k, p, 8'h00, r);
		`CHK(r, (k >= 1 && k <= 4 && p < 7) ? {24'h00_0000, m[k][p]} : 32'h0000_0000);
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Used at start and mid-run: every register must come back at zero
	task automatic reset_check();
		rst_i <= 1'b1;
		tick(8);
		rst_i <= 1'b0;
		for (int k = 1; k < 5; k++)
			for (int p = 0; p < 7; p++)
				m[k][p] = 8'h00;
		for (int k = 1; k < 5; k++)
			for (int p = 0; p < 7; p++)
				rd_reg(k, p);
		`CHK(pin_oe_o, 56'h00_0000_0000_0000);
		`CHK(drv, 56'h00_0000_0000_0000);
	endtask

	initial
	begin
		repeat (50000) @(posedge clk_i);
		timeout_hit();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		reset_check();
		$display("test reset values done");

		// Control exists on E-G only; port 7 and kinds 6, 7 are unmapped
		for (int k = 1; k < 5; k++)
			for (int p = 0; p < 8; p++)
				wr(k, p, 8'($random(seed)));
		for (int k = 1; k < 8; k++)
			for (int p = 0; p < 8; p++)
				if (k != 5)
					rd_reg(k, p);
		for (int p = 0; p < 7; p++)
			`CHK(drv[p*8 +: 8], m[4][p]);
		$display("test register readback done");

		for (int p = 4; p < 7; p++)
			wr(3, p, 8'h00);
		tick(3);
		for (int p = 0; p < 7; p++)
		begin
			`CHK(pin_oe_o[p*8 +: 8], m[2][p]);
			`CHK(pin_o[p*8 +: 8] & m[2][p], m[1][p] & m[2][p]);
		end
		pin_i <= 56'({$random(seed), $random(seed)});
		tick(4);
		for (int p = 0; p < 7; p++)
		begin
			host_model_inst.xfer(1'b0, 0, p, 8'h00, r);
			`CHK(r[7:0] & mask(p), pin_i[p*8 +: 8] & mask(p));
		end
		$display("test host io done");

		for (int p = 4; p < 7; p++)
		begin
			// Address out is only enabled by run-time writes, never relied on at boot
			wr(3, p, 8'hFF);
			wr(2, p, 8'hFF);
		end
		for (int t = 0; t < 4; t++)
		begin
			ht <= io_port_pkg::host_bus_e'(t);
			addr <= 16'($random(seed));
			tick(4);
			case (t)
				0: eo = 24'hFF_FFFF;
				1: eo = 24'h0F_F0F0;
				default: eo = 24'hFF_0000;
			endcase
			case (t)
				0: ev = {3{addr[7:0]}};
				1: ev = {4'h0, addr[11:8], addr[7:0], addr[7:0]};
				2: ev = {addr[15:8], 16'h0000};
				default: ev = {addr[7:0], 16'h0000};
			endcase
			`CHK(pin_oe_o[55:32], eo);
			`CHK(pin_o[55:32] & eo, ev & eo);
		end
		$display("test address out done");

		// Pin 0 is a logic input, so the host keeps its direction low
		wr(2, 0, 8'hFE);
		c_lin <= 56'h00_0000_0000_0001;
		c_lout <= 56'h00_0000_0000_0003;
		c_ain <= 56'h00_0000_0000_0004;
		c_rst <= 56'h00_0000_0000_0008;
		lo_oe <= 56'h00_0000_0000_0003;
		lo_out <= 56'({$random(seed), $random(seed)});
		tick(4);
		`CHK(pin_oe_o[7:0], 8'hF2);
		`CHK(pin_o[1], lo_out[1]);
		`CHK(to_logic[0], pin_i[0]);
		$display("test fixed modes done");

		ht <= io_port_pkg::HOST_MUX8;
		dport <= 1'b1;
		tport <= 1'b1;
		tick(4);
		`CHK(pin_oe_o[47:32], 16'h0000);
		`CHK(pin_oe_o[55:48], 8'hFF);
		dport <= 1'b0;
		tport <= 1'b0;
		tick(4);
		`CHK(pin_oe_o[47:32], 16'hFFFF);
		$display("test data port done");

		strobe_en <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			he <= i[0];
			hrw <= i[1];
			tick(6);
			`CHK({ext_rd, ext_wr}, {i[0] & i[1], i[0] & ~i[1]});
		end
		$display("test strobes done");
		lo_oe <= 56'h00_0000_0000_0000;
		reset_check();
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule
